/* hw/obc_boot_copier.sv */
// Boot copier: OTP to engine program RAM, with host address windows
`timescale 1ns/1ps
`default_nettype none
module obc_boot_copier
  import obc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // OTP port, one-cycle registered read
  output logic [14:0]      otp_addr,
  input  wire logic [7:0]  otp_rdata,
  // Host program fetch
  input  wire logic        host_pfetch,
  input  wire logic [15:0] host_paddr,
  output logic [7:0]       host_pdata,
  output logic             host_pc_start,
  output logic [15:0]      host_pc_reset,
  // Host data writes and reads
  input  wire logic        host_dwr,
  input  wire logic        host_drd,
  input  wire logic [15:0] host_daddr,
  input  wire logic [7:0]  host_dwdata,
  output logic             host_dhit,
  output logic [7:0]       host_drdata,
  // Engine program fetch, word addressed
  input  wire logic [12:0] eng_paddr,
  output logic [15:0]      eng_pdata,
  output logic             eng_run,
  output logic             boot_done
);
  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Host data address to RAM byte offset; valid flag in bit 14
  function automatic logic [14:0] win_map(input logic [15:0] a);
    logic [14:0] r;
    r = 15'h0000;
    if (a >= WIN0_BASE && a <= WIN0_END) begin
      r = {1'b1, 14'(a - WIN0_BASE)};
    end else if (a >= WIN1_BASE && a <= WIN1_END) begin
      r = {1'b1, 14'(a - WIN1_BASE + 16'(RAM_SEG1_BYTES))};
    end
    return r;
  endfunction : win_map

  // Keystream byte derived from RAM offset; stand-in cipher
  function automatic logic [7:0] key_of(input logic [13:0] off);
    return KEY_SEED ^ off[7:0] ^ {off[13:8], 2'b00};
  endfunction : key_of

  ////////////////////////////////////////////////////////////////////
  // Copy sequencer

  obc_state_t  state_reg, state_next;
  logic [14:0] src_reg, src_next;
  logic [13:0] dst_reg, dst_next;
  logic        done_reg, done_next;
  logic        ram_we;
  logic [13:0] ram_waddr;
  logic [7:0]  ram_wdata;

  always_comb begin
    state_next = state_reg;
    src_next   = src_reg;
    dst_next   = dst_reg;
    done_next  = done_reg;
    case (state_reg)
      OBC_IDLE: begin
        src_next   = SRC_TOP;
        dst_next   = RAM_FIRST;
        state_next = OBC_READ;
      end
      OBC_READ: begin
        // Read data returns a cycle later, so writes lag the address
        if (src_reg != SRC_LAST) begin
          src_next = src_reg - 15'h0001;
        end else begin
          state_next = OBC_LAST;
        end
        if (src_reg != SRC_TOP) begin
          dst_next = dst_reg + 14'h0001;
        end
      end
      OBC_LAST: begin
        state_next = OBC_DONE;
        done_next  = 1'b1;
      end
      OBC_DONE: begin
        state_next = OBC_DONE;
      end
      default: begin
        state_next = OBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= OBC_IDLE;
      src_reg   <= SRC_TOP;
      dst_reg   <= RAM_FIRST;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      src_reg   <= src_next;
      dst_reg   <= dst_next;
      done_reg  <= done_next;
    end
  end

  // Write pending once the first read returned; covers all 12K bytes
  logic       cp_we;
  logic [14:0] hw_map;
  assign cp_we  = (state_reg == OBC_READ && src_reg != SRC_TOP)
                  || state_reg == OBC_LAST;
  assign hw_map = win_map(host_daddr);

  always_comb begin
    ram_we    = 1'b0;
    ram_waddr = dst_reg;
    ram_wdata = otp_rdata ^ key_of(dst_reg);
    if (cp_we) begin
      ram_we = 1'b1;
    end else if (host_dwr && hw_map[14]) begin
      ram_we    = 1'b1;
      ram_waddr = hw_map[13:0];
      ram_wdata = host_dwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // OTP port and host side

  // Engine has no path to OTP: only the copier and host fetch drive it
  // Fetches wait for the copy to end, so they never steal a copy read
  logic [14:0] otp_addr_next;
  logic        pfetch_next;
  logic        pfetch_reg;
  logic        pvalid_reg;
  always_comb begin
    otp_addr_next = src_next;
    pfetch_next   = 1'b0;
    if (state_reg == OBC_DONE && host_pfetch && host_paddr <= 16'(OTP_LAST)) begin
      otp_addr_next = host_paddr[14:0];
      pfetch_next   = 1'b1;
    end
  end

  // OTP data trails its address by one cycle, so capture trails by two
  logic [7:0]  pdata_next;
  logic        dhit_next;
  always_comb begin
    pdata_next = host_pdata;
    if (pvalid_reg) begin
      pdata_next = otp_rdata;
    end
    dhit_next = (host_dwr || host_drd) && hw_map[14];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      otp_addr      <= SRC_TOP;
      pfetch_reg    <= 1'b0;
      pvalid_reg    <= 1'b0;
      host_pdata    <= DATA_RESET;
      host_dhit     <= 1'b0;
      host_drdata   <= DATA_RESET;
      host_pc_start <= 1'b0;
      host_pc_reset <= HOST_PC_RESET;
      eng_run       <= 1'b0;
      boot_done     <= 1'b0;
    end else begin
      otp_addr      <= otp_addr_next;
      pfetch_reg    <= pfetch_next;
      pvalid_reg    <= pfetch_reg;
      host_pdata    <= pdata_next;
      host_dhit     <= dhit_next;
      host_drdata   <= DATA_RESET;
      host_pc_start <= 1'b1;
      host_pc_reset <= HOST_PC_RESET;
      eng_run       <= done_reg;
      boot_done     <= done_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Program RAM, two byte banks forming engine 16-bit words

  logic [7:0] lo_q, hi_q;
  obc_prog_ram u_ram_lo (
    .clk   (clk),
    .we    (ram_we && !ram_waddr[0]),
    .waddr ({1'b0, ram_waddr[13:1]}),
    .wdata (ram_wdata),
    .raddr ({1'b0, eng_paddr}),
    .rdata (lo_q)
  );
  obc_prog_ram u_ram_hi (
    .clk   (clk),
    .we    (ram_we && ram_waddr[0]),
    .waddr ({1'b0, ram_waddr[13:1]}),
    .wdata (ram_wdata),
    .raddr ({1'b0, eng_paddr}),
    .rdata (hi_q)
  );

  // Engine sees zeros until boot is complete
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eng_pdata <= 16'h0000;
    end else begin
      eng_pdata <= done_reg ? {hi_q, lo_q} : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  a_src_start_top: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == OBC_IDLE |=> src_reg == SRC_TOP)
    else $error("copy did not start at top minus one");
  a_first_dest_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (cp_we && src_reg == 15'h7FFD) |-> dst_reg == RAM_FIRST)
    else $error("first byte not at RAM offset zero");
  a_seg2_map: assert property (@(posedge clk) disable iff (!rst_n)
    (cp_we && state_reg == OBC_READ && src_reg == 15'h5FFD) |-> dst_reg == RAM_SEG1_BYTES)
    else $error("segment two start misplaced");
  a_last_dest: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == OBC_LAST |-> dst_reg == RAM_LAST)
    else $error("copy length not full image");
  a_engine_held: assert property (@(posedge clk) disable iff (!rst_n)
    !boot_done |-> !eng_run && eng_pdata == 16'h0000)
    else $error("engine ran before boot end");
  a_no_readback: assert property (@(posedge clk) disable iff (!rst_n)
    $past(host_drd) |-> host_drdata == DATA_RESET)
    else $error("program RAM readable by host");
  a_decrypt_path: assert property (@(posedge clk) disable iff (!rst_n)
    cp_we |-> ram_wdata == (otp_rdata ^ key_of(dst_reg)))
    else $error("byte written without decryption");
  a_win_hit: assert property (@(posedge clk) disable iff (!rst_n)
    (host_dwr && host_daddr == 16'hE000) |=> host_dhit)
    else $error("second window not decoded");

  // Copy order and RAM ownership
  a_src_step: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == OBC_READ && src_reg != SRC_LAST) |=> src_reg == $past(src_reg) - 15'h0001)
    else $error("source address did not step down by one");
  a_last_write: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == OBC_LAST |-> ram_we && ram_waddr == RAM_LAST)
    else $error("last image byte not written");
  a_copy_owns_ram: assert property (@(posedge clk) disable iff (!rst_n)
    (cp_we && host_dwr) |-> ram_waddr == dst_reg)
    else $error("host write displaced a copy write");
  a_no_prot_byte: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg != OBC_DONE |-> otp_addr != OTP_LAST)
    else $error("protection byte read during copy");

  // Host windows and fetch path
  a_win0_base: assert property (@(posedge clk) disable iff (!rst_n)
    (boot_done && host_dwr && host_daddr == WIN0_BASE) |-> ram_we && ram_waddr == RAM_FIRST)
    else $error("first window base misplaced");
  a_win1_base: assert property (@(posedge clk) disable iff (!rst_n)
    (boot_done && host_dwr && host_daddr == WIN1_BASE) |-> ram_we && ram_waddr == RAM_SEG1_BYTES)
    else $error("second window base misplaced");
  a_win1_end: assert property (@(posedge clk) disable iff (!rst_n)
    (boot_done && host_dwr && host_daddr == WIN1_END) |-> ram_we && ram_waddr == RAM_LAST)
    else $error("second window end misplaced");
  a_win_miss: assert property (@(posedge clk) disable iff (!rst_n)
    ((host_dwr || host_drd) && host_daddr > WIN0_END && host_daddr < WIN1_BASE) |=> !host_dhit)
    else $error("window hit outside program RAM");
  a_fetch_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (boot_done && host_pfetch && host_paddr <= 16'(OTP_LAST))
      |=> {1'b0, otp_addr} == $past(host_paddr))
    else $error("host fetch address not passed to OTP");
  a_fetch_data: assert property (@(posedge clk) disable iff (!rst_n)
    pvalid_reg |=> host_pdata == $past(otp_rdata))
    else $error("host fetch data not taken from OTP");
  a_fetch_refused: assert property (@(posedge clk) disable iff (!rst_n)
    !boot_done |-> host_pdata == DATA_RESET)
    else $error("host fetch served during copy");

  // Engine side
  a_eng_word: assert property (@(posedge clk) disable iff (!rst_n)
    done_reg |=> eng_pdata == {$past(hi_q), $past(lo_q)})
    else $error("engine word not odd byte over even byte");
  a_run_stays: assert property (@(posedge clk) disable iff (!rst_n)
    eng_run |=> eng_run && boot_done)
    else $error("engine run dropped before reset");
endmodule : obc_boot_copier
`default_nettype wire

/* hw/obc_pkg.sv */
// Package for the program boot copier: sizes, address windows, reset values
package obc_pkg;
  localparam int unsigned   IMG_BYTES       = 12288;
  localparam logic [14:0]   SRC_TOP         = 15'h7FFE;
  localparam logic [14:0]   SRC_LAST        = 15'h4FFF;
  localparam logic [14:0]   OTP_LAST        = 15'h7FFF;
  localparam logic [13:0]   RAM_FIRST       = 14'h0000;
  localparam logic [13:0]   RAM_LAST        = 14'h2FFF;
  localparam logic [13:0]   RAM_SEG1_BYTES  = 14'h2000;
  localparam logic [15:0]   WIN0_BASE       = 16'h6000;
  localparam logic [15:0]   WIN0_END        = 16'h7FFF;
  localparam logic [15:0]   WIN1_BASE       = 16'hE000;
  localparam logic [15:0]   WIN1_END        = 16'hEFFF;
  localparam logic [15:0]   HOST_PC_RESET   = 16'h0000;
  localparam logic [7:0]    KEY_SEED        = 8'h5A;
  localparam logic [7:0]    DATA_RESET      = 8'h00;

  typedef enum logic [1:0] {
    OBC_IDLE = 2'b00,
    OBC_READ = 2'b01,
    OBC_LAST = 2'b10,
    OBC_DONE = 2'b11
  } obc_state_t;
endpackage : obc_pkg

/* hw/obc_prog_ram.sv */
// Motion engine program RAM, 12K bytes, registered read data
`timescale 1ns/1ps
`default_nettype none
module obc_prog_ram
  import obc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        we,
  input  wire logic [13:0] waddr,
  input  wire logic [7:0]  wdata,
  input  wire logic [13:0] raddr,
  output var  logic [7:0]  rdata
);
  logic [7:0] mem [0:IMG_BYTES-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : obc_prog_ram
`default_nettype wire

/* dv/obc_otp_model.sv */
// Behavioural OTP program memory with one-cycle registered read
`timescale 1ns/1ps
`default_nettype none
module obc_otp_model (
  input  wire logic        clk,
  input  wire logic [14:0] addr,
  output var  logic [7:0]  rdata
);
  // Image written by the bench; one random array read by both host fetch and copy
  logic [7:0] mem [0:32767];
  always_ff @(posedge clk) begin
    rdata <= mem[addr];
  end
endmodule : obc_otp_model
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the boot copier
`timescale 1ns/1ps
`default_nettype none
module tb;
  import obc_pkg::*;
  logic        clk, rst_n, host_pfetch, host_dwr, host_drd;
  logic [15:0] host_paddr, host_daddr, host_pc_reset, eng_pdata;
  logic [7:0]  host_dwdata, host_pdata, host_drdata, otp_rdata;
  logic [14:0] otp_addr;
  logic [12:0] eng_paddr;
  logic        host_pc_start, host_dhit, eng_run, boot_done;
  logic [7:0]  ref_ram [0:12287];
  logic [14:0] min_a = 15'h7FFF;
  int          failures, n_compared, seed, cyc, i, k;
  int          ws[5] = '{0, 1, 4095, 4096, 6143};
  obc_boot_copier u_obc_boot_copier (.clk(clk), .rst_n(rst_n), .otp_addr(otp_addr),
    .otp_rdata(otp_rdata), .host_pfetch(host_pfetch), .host_paddr(host_paddr),
    .host_pdata(host_pdata), .host_pc_start(host_pc_start), .host_pc_reset(host_pc_reset),
    .host_dwr(host_dwr), .host_drd(host_drd), .host_daddr(host_daddr),
    .host_dwdata(host_dwdata), .host_dhit(host_dhit), .host_drdata(host_drdata),
    .eng_paddr(eng_paddr), .eng_pdata(eng_pdata), .eng_run(eng_run), .boot_done(boot_done));
  obc_otp_model u_obc_otp_model (.clk(clk), .addr(otp_addr), .rdata(otp_rdata));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////
  task automatic eng_word(int w);
    @(posedge clk) eng_paddr <= w[12:0];
    repeat (2) @(posedge clk);
    #1 chk("eng_pdata", {ref_ram[2*w+1], ref_ram[2*w]}, eng_pdata);
  endtask : eng_word
  // Host data access; only writes after boot land in the RAM
  task automatic hacc(logic [15:0] a, logic [7:0] d, logic wr, logic hit);
    @(posedge clk) begin
      host_daddr <= a;
      host_dwdata <= d;
      host_dwr <= wr;
      host_drd <= !wr;
    end
    @(posedge clk) begin
      host_dwr <= 0;
      host_drd <= 0;
    end
    #1 chk("host_dhit", hit, host_dhit);
    if (!wr) chk("host_drdata", 0, host_drdata);
    if (wr && hit && boot_done === 1)
      ref_ram[a >= 16'hE000 ? a - 16'hE000 + 16'h2000 : a - 16'h6000] = d;
  endtask : hacc
  task automatic fetch(logic [15:0] a);
    @(posedge clk) begin
      host_pfetch <= 1;
      host_paddr <= a;
    end
    repeat (3) @(posedge clk);
    #1 chk("host_pdata", u_obc_otp_model.mem[a[14:0]], host_pdata);
  endtask : fetch
  ////////////////////////////////////////////////////////////////////////
  // Watchdog, protection byte and lowest source address seen
  always @(posedge clk) begin
    if (rst_n === 1 && boot_done !== 1 && otp_addr === 15'h7FFF) begin
      $display("MISMATCH otp_addr expected below 7fff seen %h", otp_addr);
      failures++;
    end
    if (rst_n === 1 && boot_done !== 1 && otp_addr < min_a) min_a <= otp_addr;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    {rst_n, host_pfetch, host_dwr, host_drd} = 0;
    {host_paddr, host_daddr, host_dwdata, eng_paddr} = 0;
    seed = 71;
    for (i = 0; i < 32768; i++) u_obc_otp_model.mem[i] = $random(seed);
    // Reference: descending source, byte cipher on the way
    for (i = 0; i < 12288; i++)
      ref_ram[i] = u_obc_otp_model.mem[15'h7FFE - i] ^ KEY_SEED ^ i[7:0] ^ {i[13:8], 2'b00};
    repeat (8) @(posedge clk);
    rst_n <= 1;
    // Early fetch must be ignored until the copy ends
    host_pfetch <= 1;
    host_paddr <= 16'h0123;
    repeat (100) @(posedge clk);
    hacc(16'h6000, 8'hA5, 1, 1); // Dropped: copy owns the RAM
    chk("boot_done", 0, boot_done);
    chk("eng_run", 0, eng_run);
    chk("eng_pdata", 0, eng_pdata);
    chk("host_pdata", 0, host_pdata);
    chk("host_pc_start", 1, host_pc_start);
    chk("host_pc_reset", 0, host_pc_reset);
    k = 0;
    while (boot_done !== 1 && k < 13000) begin
      @(posedge clk);
      k++;
    end
    #1 chk("boot_done", 1, boot_done);
    chk("eng_run", 1, eng_run);
    chk("lowest source", 15'h4FFF, min_a);
    $display("test boot done");
    foreach (ws[j]) eng_word(ws[j]);
    for (i = 0; i < 40; i++) eng_word($unsigned($random(seed)) % 6144);
    $display("test copy image done");
    foreach (ws[j]) begin
      hacc(16'h6000 + ws[j][12:0], $random(seed), 1, 1);
      hacc(16'h5FFF + ws[j][15:0], 0, 0, ws[j] != 0);
    end
    hacc(16'hE000, 8'h3C, 1, 1);
    hacc(16'hEFFF, 8'hC3, 1, 1);
    hacc(16'hF000, 8'h77, 1, 0);
    hacc(16'h8000, 8'h77, 1, 0);
    foreach (ws[j]) eng_word(ws[j]);
    eng_word(4096);
    $display("test host window done");
    fetch(16'h0000);
    fetch(16'h7FFF);
    for (i = 0; i < 20; i++) fetch($random(seed) & 16'h7FFF);
    $display("test host fetch done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
